// *** logic/sbt_pkg.sv ***
// Purpose: Shared constants and types for the SDRAM burst data path.
// Assumes: 100 MHz system clock; commands sampled on its rising edge.
// Notes: Timing counts are derived from nanosecond figures below.
package sbt_pkg;
  localparam int CLK_NS = 10;
  localparam int WR_NS = 15;
  localparam int RP_NS = 20;
  localparam int WR_RAW = (WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_RAW = (RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (WR_RAW < 1) ? 1 : WR_RAW;
  localparam int RP_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
  // Write auto precharge waits one extra clock for completion
  localparam logic [3:0] AP_WR_CNT = 4'(WR_CYC + 1);
  localparam logic [3:0] RP_CNT = 4'(RP_CYC);
  localparam logic [3:0] ONE4 = 4'h1;

  // {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam int ALL_BANKS_BIT = 10;

  localparam logic [2:0] BL_CONT = 3'h7;
  localparam logic [2:0] BL_MAX = 3'h3;
  localparam logic [1:0] RL_MIN = 2'h2;
  localparam logic [1:0] RL_MAX = 2'h3;

  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CFG_RL_LSB = 0;
  localparam int CFG_BL_LSB = 4;
  localparam int CFG_SW_BIT = 8;
  localparam logic [1:0] RL_RST = 2'h2;
  localparam logic [2:0] BL_RST = 3'h2;
  localparam int STAT_PRE_LSB = 4;
  localparam int STAT_RD_BIT = 8;
  localparam int STAT_WR_BIT = 9;

  typedef struct packed {
    logic act;
    logic cont;
    logic ap;
    logic [1:0] bank;
    logic [2:0] cnt;
  } sbt_burst_t;

  // Elements left after the first one, for a length code
  function automatic logic [2:0] sbt_rest_f(input logic [2:0] bl);
    sbt_rest_f = 3'((4'h1 << bl[1:0]) - 4'h1);
  endfunction : sbt_rest_f
endpackage : sbt_pkg

// *** logic/sbt_top.sv ***
// Purpose: Burst read/write data path and truncation of an SDRAM device.
// Assumes: Controller drives pins on SYS_CLK_I; config reached over APB.
// Notes: Sequential burst order only; refresh and init are not modelled.
//
// Chosen here: the register addresses and the APB slave port.

// Functional notes
// - Precharge cuts a plain fixed read, issued latency minus one early.
// - Explicit precharge of the burst's bank, or of all banks, ends it, like auto precharge when timed well.
// - Burst stop ends a read, issued latency minus one early.
// - Write data sampled on the command edge, then every later edge.
// - After a finished write burst further input data is ignored.
// - Continuous bursts wrap from page end to column zero.
// - A new write may follow on any cycle and ends the old burst.
// - A read registered during a write stops all further writes.
// - Write auto precharge waits recovery plus one clock before closing.
// - Burst stop ends a write; data on the stop edge is discarded.
// - Read and write carry column, bank and auto precharge choice.
// - Mask blanks read output two clocks after it is sampled.
// - First read element appears read latency after the command.
// - Precharge with all-banks bit closes every bank, else the selected one.
module sbt_top #(
  parameter int DW = 16,
  parameter int ROW_W = 12,
  parameter int COL_W = 9
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [1:0] BA_I,
  input wire logic [ROW_W-1:0] ADDR_I,
  input wire logic DQM_I,
  input wire logic [DW-1:0] DQ_I,
  output logic [DW-1:0] DQ_O,
  output logic DQ_OE_O,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);
  initial begin
    if (ROW_W <= sbt_pkg::ALL_BANKS_BIT || COL_W > sbt_pkg::ALL_BANKS_BIT ||
        COL_W < 3 || DW < 1 || DW > 32)
      $error("sbt_top: unsupported width parameters");
  end

  localparam int MA_W = 2 + ROW_W + COL_W;

  typedef struct packed {
    logic [1:0] rl;
    logic [2:0] bl;
    logic sw;
    sbt_pkg::sbt_burst_t rd;
    logic [COL_W-1:0] rd_col;
    sbt_pkg::sbt_burst_t wr;
    logic [COL_W-1:0] wr_col;
    logic [2:0] pv;
    logic [2:0][DW-1:0] pd;
    logic [1:0] mq;
    logic [3:0][ROW_W-1:0] row;
    logic [3:0] open;
    logic [3:0][3:0] ap_t;
    logic [3:0][3:0] rp_t;
    logic [31:0] prdata;
    logic slverr;
  } sbt_state_t;

  sbt_state_t st_q, st_d;
  logic [1:0] rs_q;
  logic rst_n;
  logic [DW-1:0] mem [2**MA_W];
  logic we;
  logic [MA_W-1:0] waddr;
  logic [DW-1:0] wdat;

  // Next column: fixed bursts wrap in their block, continuous in the page
  function automatic logic [COL_W-1:0] nxt_col(input logic [COL_W-1:0] c,
                                               input logic [2:0] bl);
    logic [COL_W-1:0] inc;
    logic [COL_W-1:0] msk;
    inc = c + COL_W'(1);
    msk = COL_W'((4'h1 << bl[1:0]) - 4'h1);
    if (bl == sbt_pkg::BL_CONT) begin
      nxt_col = inc;
    end else begin
      nxt_col = (c & ~msk) | (inc & msk);
    end
  endfunction : nxt_col

  function automatic logic [MA_W-1:0] maddr(input logic [1:0] b,
                                            input logic [ROW_W-1:0] r,
                                            input logic [COL_W-1:0] c);
    maddr = {b, r, c};
  endfunction : maddr

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];

  logic sel;
  logic [2:0] cmd;
  logic is_act, is_rd, is_wr, is_pre, is_bst, all_b;
  logic hit_rd, hit_wr, rd_stop, wr_stop;
  logic [COL_W-1:0] acol;
  logic apb_set;

  assign sel = !CS_N_I;
  assign cmd = {RAS_N_I, CAS_N_I, WE_N_I};
  assign is_act = sel && cmd == sbt_pkg::CMD_ACT;
  assign is_rd = sel && cmd == sbt_pkg::CMD_RD;
  assign is_wr = sel && cmd == sbt_pkg::CMD_WR;
  assign is_pre = sel && cmd == sbt_pkg::CMD_PRE;
  assign is_bst = sel && cmd == sbt_pkg::CMD_BST;
  assign all_b = ADDR_I[sbt_pkg::ALL_BANKS_BIT];
  assign acol = ADDR_I[COL_W-1:0];
  assign hit_rd = is_pre && (all_b || BA_I == st_q.rd.bank);
  assign hit_wr = is_pre && (all_b || BA_I == st_q.wr.bank);
  assign rd_stop = is_rd || is_wr || is_bst || hit_rd;
  assign wr_stop = is_rd || is_wr || is_bst || hit_wr;
  assign apb_set = PSEL_I && !PENABLE_I;

  always_comb begin
    st_d = st_q;
    we = 1'b0;
    waddr = '0;
    wdat = DQ_I;
    st_d.pv = {st_q.pv[1:0], 1'b0};
    st_d.pd = {st_q.pd[1:0], st_q.pd[0]};
    st_d.mq = {st_q.mq[0], DQM_I};
    for (int b = 0; b < 4; b++) begin
      if (st_q.rp_t[b] != 4'h0) begin
        st_d.rp_t[b] = st_q.rp_t[b] - sbt_pkg::ONE4;
      end
      if (st_q.ap_t[b] != 4'h0) begin
        st_d.ap_t[b] = st_q.ap_t[b] - sbt_pkg::ONE4;
        if (st_q.ap_t[b] == sbt_pkg::ONE4) begin
          st_d.open[b] = 1'b0;
          st_d.rp_t[b] = sbt_pkg::RP_CNT;
        end
      end
    end
    if (st_q.rd.act) begin
      if (rd_stop) begin
        st_d.rd.act = 1'b0;
        if (st_q.rd.ap) begin
          st_d.ap_t[st_q.rd.bank] = sbt_pkg::ONE4;
        end
      end else begin
        st_d.pv[0] = 1'b1;
        st_d.pd[0] = mem[maddr(st_q.rd.bank, st_q.row[st_q.rd.bank],
                               st_q.rd_col)];
        st_d.rd_col = nxt_col(st_q.rd_col, st_q.bl);
        st_d.rd.cnt = st_q.rd.cnt - 3'h1;
        if (!st_q.rd.cont && st_q.rd.cnt == 3'h1) begin
          st_d.rd.act = 1'b0;
          if (st_q.rd.ap) begin
            st_d.ap_t[st_q.rd.bank] = sbt_pkg::ONE4;
          end
        end
      end
    end
    if (st_q.wr.act) begin
      if (wr_stop) begin
        st_d.wr.act = 1'b0;
        if (st_q.wr.ap) begin
          st_d.ap_t[st_q.wr.bank] = sbt_pkg::AP_WR_CNT;
        end
      end else begin
        we = !DQM_I;
        waddr = maddr(st_q.wr.bank, st_q.row[st_q.wr.bank], st_q.wr_col);
        st_d.wr_col = nxt_col(st_q.wr_col, st_q.bl);
        st_d.wr.cnt = st_q.wr.cnt - 3'h1;
        if (!st_q.wr.cont && st_q.wr.cnt == 3'h1) begin
          st_d.wr.act = 1'b0;
          if (st_q.wr.ap) begin
            st_d.ap_t[st_q.wr.bank] = sbt_pkg::AP_WR_CNT;
          end
        end
      end
    end
    if (is_rd) begin
      st_d.pv[0] = 1'b1;
      st_d.pd[0] = mem[maddr(BA_I, st_q.row[BA_I], acol)];
      st_d.rd.bank = BA_I;
      st_d.rd.cont = st_q.bl == sbt_pkg::BL_CONT;
      st_d.rd.ap = all_b && !st_d.rd.cont;
      st_d.rd.cnt = sbt_pkg::sbt_rest_f(st_q.bl);
      st_d.rd.act = st_d.rd.cont || st_d.rd.cnt != 3'h0;
      st_d.rd_col = nxt_col(acol, st_q.bl);
      if (st_d.rd.ap && !st_d.rd.act) begin
        st_d.ap_t[BA_I] = sbt_pkg::ONE4;
      end
    end
    if (is_wr) begin
      st_d.pv = 3'h0;
      we = !DQM_I;
      waddr = maddr(BA_I, st_q.row[BA_I], acol);
      st_d.wr.bank = BA_I;
      st_d.wr.cont = st_q.bl == sbt_pkg::BL_CONT;
      st_d.wr.ap = all_b && !st_d.wr.cont;
      st_d.wr.cnt = st_q.sw ? 3'h0 : sbt_pkg::sbt_rest_f(st_q.bl);
      st_d.wr.act = st_d.wr.cont || st_d.wr.cnt != 3'h0;
      st_d.wr_col = nxt_col(acol, st_q.bl);
      if (st_d.wr.ap && !st_d.wr.act) begin
        st_d.ap_t[BA_I] = sbt_pkg::AP_WR_CNT;
      end
    end
    if (is_act) begin
      st_d.row[BA_I] = ADDR_I;
      st_d.open[BA_I] = 1'b1;
    end
    if (is_pre) begin
      for (int b = 0; b < 4; b++) begin
        if (all_b || BA_I == 2'(b)) begin
          st_d.open[b] = 1'b0;
          st_d.ap_t[b] = 4'h0;
          st_d.rp_t[b] = sbt_pkg::RP_CNT;
        end
      end
    end
    if (apb_set) begin
      st_d.slverr = 1'b0;
      st_d.prdata = 32'h0;
      if (PADDR_I == sbt_pkg::CFG_OFS) begin
        st_d.prdata[sbt_pkg::CFG_RL_LSB+:2] = st_q.rl;
        st_d.prdata[sbt_pkg::CFG_BL_LSB+:3] = st_q.bl;
        st_d.prdata[sbt_pkg::CFG_SW_BIT] = st_q.sw;
      end else if (PADDR_I == sbt_pkg::STAT_OFS) begin
        st_d.prdata[3:0] = st_q.open;
        for (int b = 0; b < 4; b++) begin
          st_d.prdata[sbt_pkg::STAT_PRE_LSB+b] = st_q.rp_t[b] != 4'h0;
        end
        st_d.prdata[sbt_pkg::STAT_RD_BIT] = st_q.rd.act;
        st_d.prdata[sbt_pkg::STAT_WR_BIT] = st_q.wr.act;
      end else begin
        st_d.slverr = 1'b1;
      end
    end
    if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == sbt_pkg::CFG_OFS) begin
      if (PWDATA_I[sbt_pkg::CFG_RL_LSB+:2] >= sbt_pkg::RL_MIN) begin
        st_d.rl = PWDATA_I[sbt_pkg::CFG_RL_LSB+:2];
      end
      if (PWDATA_I[sbt_pkg::CFG_BL_LSB+:3] <= sbt_pkg::BL_MAX ||
          PWDATA_I[sbt_pkg::CFG_BL_LSB+:3] == sbt_pkg::BL_CONT) begin
        st_d.bl = PWDATA_I[sbt_pkg::CFG_BL_LSB+:3];
      end
      st_d.sw = PWDATA_I[sbt_pkg::CFG_SW_BIT];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.rl <= sbt_pkg::RL_RST;
      st_q.bl <= sbt_pkg::BL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (we) begin
      mem[waddr] <= wdat;
    end
  end

  // Read data leaves the pipe latency minus one stages after the fetch
  logic [1:0] pidx;
  assign pidx = st_q.rl - 2'h1;
  assign DQ_OE_O = st_q.pv[pidx] && !st_q.mq[1];
  assign DQ_O = st_q.pd[pidx];
  assign PRDATA_O = st_q.prdata;
  assign PSLVERR_O = PSEL_I && PENABLE_I && st_q.slverr;
  assign PREADY_O = PSEL_I && PENABLE_I;

  default clocking dc @(posedge SYS_CLK_I); endclocking
  default disable iff (!rst_n);

  chk_rd_latency: assert property (
    is_rd && st_q.rl == sbt_pkg::RL_MIN && !DQM_I ##1 !is_wr |-> ##1 DQ_OE_O)
    else $error("read data not driven at latency");
  chk_rd_mask: assert property (DQM_I |-> ##2 !DQ_OE_O)
    else $error("masked read data driven");
  chk_mask_write: assert property (DQM_I |-> !we)
    else $error("masked element written");
  chk_bst_write: assert property (is_bst |-> !we)
    else $error("data written on burst stop edge");
  chk_wr_idle: assert property (!st_q.wr.act && !is_wr |-> !we)
    else $error("write outside a burst");
  chk_rd_ends_wr: assert property (
    is_rd |-> !we ##1 (!st_q.wr.act && (is_wr || !we)))
    else $error("write continued after read");
  chk_wr_quiet: assert property (st_q.wr.act |-> !DQ_OE_O)
    else $error("read data driven during write burst");
  chk_rd_stop: assert property (is_bst |=> !st_q.rd.act)
    else $error("read burst not stopped");
  chk_pre_all: assert property (
    is_pre && all_b |=> st_q.open == 4'h0 && st_q.rp_t[0] == sbt_pkg::RP_CNT)
    else $error("all-bank precharge incomplete");
  chk_page_wrap: assert property (
    st_q.wr.act && st_q.wr.cont && &st_q.wr_col && !wr_stop
    |=> st_q.wr_col == '0)
    else $error("continuous burst did not wrap");
  chk_wr_first: assert property (is_wr && !DQM_I |-> we)
    else $error("first write element not taken");
  chk_rd_latency3: assert property (
    is_rd && st_q.rl == sbt_pkg::RL_MAX ##1 !is_wr && !DQM_I ##1 !is_wr
    |-> ##1 DQ_OE_O)
    else $error("read data not driven at long latency");
  chk_pre_cuts_wr: assert property (hit_wr |-> !we)
    else $error("data written on precharge edge");
  chk_rd_pre_stop: assert property (hit_rd |=> !st_q.rd.act)
    else $error("read burst not cut by precharge");
  chk_wr_ap_hold: assert property (
    st_q.wr.act && st_q.wr.ap && st_q.wr.cnt == 3'h1 && !wr_stop
    |=> st_q.ap_t[st_q.wr.bank] == sbt_pkg::AP_WR_CNT)
    else $error("write auto precharge started early");
  chk_bank_close: assert property (
    st_q.ap_t[0] == sbt_pkg::ONE4 && !(is_act && BA_I == 2'h0)
    |=> !st_q.open[0])
    else $error("auto precharge left bank open");

  cov_rd_burst: cover property (is_rd ##1 st_q.rd.act [*3] ##1 DQ_OE_O);
  cov_wr_burst: cover property (is_wr ##1 we [*3]);
  cov_rd_bst: cover property (st_q.rd.act && is_bst);
  cov_wr_pre: cover property (st_q.wr.act && hit_wr);
  cov_rd_pre: cover property (st_q.rd.act && hit_rd);
endmodule : sbt_top

// *** testbench/sbt_ctrl_model.sv ***
// Purpose: Memory controller model driving commands, mask and data.
// Assumes: Each step starts just after a rising clock edge.
// Notes: Released data lines show the inverse of the last value.
module sbt_ctrl_model (
  input wire logic clk_i,
  output logic [3:0] cmd_o,
  output logic [11:0] addr_o,
  output logic dqm_o,
  output logic [15:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial {cmd_o, addr_o, dqm_o, dq_o} = {4'hF, 29'h0000_0000};

  // One clock of command with its data, and its mask unless the command is a write
  task automatic go(input logic [2:0] op, input logic [11:0] a,
                    input logic m, input logic drv, input logic [15:0] d);
    cmd_o <= {1'b0, op};
    addr_o <= a;
    dqm_o <= m && op != sbt_pkg::CMD_WR;
    dq_o <= drv ? d : ~dq_o;
    @(posedge clk_i);
  endtask : go

  // Close banks, then leave them alone for the precharge period
  task automatic pre(input logic all);
    go(sbt_pkg::CMD_PRE, 12'(all) << sbt_pkg::ALL_BANKS_BIT, 1'b0, 1'b0,
       16'h0000);
    repeat (int'(sbt_pkg::RP_CNT))
      go(3'h7, 12'h000, 1'b0, 1'b0, 16'h0000);
  endtask : pre
endmodule : sbt_ctrl_model

// *** testbench/sbt_burst_truncation_test.sv ***
// Purpose: Self-checking bench for the burst data path.
// Assumes: Bank 0 row 0 only; read data checked in arrival order.
// Notes: A reference array mirrors every write the device should keep.
module sbt_burst_truncation_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] NOP = 3'h7;
  localparam logic [2:0] RD = sbt_pkg::CMD_RD;
  localparam logic [2:0] WR = sbt_pkg::CMD_WR;
  localparam logic [2:0] BST = sbt_pkg::CMD_BST;
  localparam logic [2:0] ACT = sbt_pkg::CMD_ACT;
  localparam int AP = 1 << sbt_pkg::ALL_BANKS_BIT;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic oe;
  logic dqm;
  logic [3:0] cmd;
  logic [11:0] addr;
  logic [15:0] dq;
  logic [15:0] dqo;
  logic [15:0] lfsr = 16'h005D;
  logic [15:0] exp_q[$];
  logic [15:0] ref_m[int];
  int rl = 2;
  int wm = 3;
  int num_errors = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  sbt_top sbt_top_inst (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cmd[3]), .RAS_N_I(cmd[2]),
    .CAS_N_I(cmd[1]), .WE_N_I(cmd[0]), .BA_I(2'h0), .ADDR_I(addr),
    .DQM_I(dqm), .DQ_I(dq), .DQ_O(dqo), .DQ_OE_O(oe), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr)
  );

  sbt_ctrl_model sbt_ctrl_model_inst (
    .clk_i(clk), .cmd_o(cmd), .addr_o(addr), .dqm_o(dqm), .dq_o(dq)
  );

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  // Column of element k, wrapping inside the burst block or the page
  function automatic int adr(int col, int k);
    return (col & ~wm) | ((col + k) & wm);
  endfunction : adr

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  always @(posedge clk) begin
    if (oe === 1'b1 && exp_q.size() == 0)
      chk("read extra", 32'h1, 32'h0);
    else if (oe === 1'b1)
      chk("read data", 32'(dqo), 32'(exp_q.pop_front()));
  end

  task automatic c(logic [2:0] op, int a, logic m, logic drv,
                   logic [15:0] d);
    sbt_ctrl_model_inst.go(op, 12'(a), m, drv, d);
  endtask : c

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic [31:0] e, logic err);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("apb ready", 32'(pready), 32'h1);
    chk("apb error", 32'(pslverr), 32'(err));
    if (!w) chk("apb read", prdata, e);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic cfg(int r, int b);
    logic [31:0] v = 32'(b << sbt_pkg::CFG_BL_LSB | r);
    apb(1'b1, sbt_pkg::CFG_OFS, v, 32'h0, 1'b0);
    apb(1'b0, sbt_pkg::CFG_OFS, 32'h0, v, 1'b0);
    rl = r;
    wm = (b == 7) ? 511 : (1 << b) - 1;
  endtask : cfg

  // Write n elements from col, masking element mk
  task automatic wb(int col, int n, int mk);
    logic [15:0] d;
    for (int k = 0; k < n; k++) begin
      d = rnd();
      if (k != mk) ref_m[adr(col, k)] = d;
      c(k == 0 ? WR : NOP, col, k == mk, 1'b1, d);
    end
  endtask : wb

  // Read m elements, blank element bj, cut by sop at the latest edge
  task automatic rd(int col, int m, int bj, logic [2:0] sop);
    for (int k = 0; k < m; k++)
      if (k != bj) exp_q.push_back(ref_m[adr(col, k)]);
    c(RD, col, 1'b0, 1'b1, rnd());
    for (int i = 1; i < m + rl + 3; i++)
      c(i == m ? sop : NOP, 0, i == rl + bj - 2, 1'b0, 16'h0);
    chk("read count", 32'(exp_q.size()), 32'h0);
  endtask : rd

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, 32'h0, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b0, sbt_pkg::CFG_OFS, 32'h0, 32'h0000_0022, 1'b0);
    apb(1'b0, sbt_pkg::STAT_OFS, 32'h0, 32'h0, 1'b0);
    $display("test registers done");
    cfg(2, 3);
    c(ACT, 0, 1'b0, 1'b0, 16'h0);
    wb(0, 8, -1);
    repeat (sbt_pkg::WR_CYC) c(NOP, 0, 1'b0, 1'b1, rnd());
    sbt_ctrl_model_inst.pre(1'b1);
    c(ACT, 0, 1'b0, 1'b0, 16'h0);
    wb(0, 3, 1);
    c(BST, 0, 1'b0, 1'b1, rnd());
    rd(0, 8, -1, NOP);
    $display("test masked write done");
    wb(0, 2, -1);
    wb(5, 2, -1);
    rd(0, 8, -1, NOP);
    $display("test write truncation done");
    wb(0, 3, -1);
    c(NOP, 0, 1'b1, 1'b1, rnd());
    c(sbt_pkg::CMD_PRE, 0, 1'b1, 1'b1, rnd());
    repeat (int'(sbt_pkg::RP_CNT)) c(NOP, 0, 1'b0, 1'b0, 16'h0);
    c(ACT, 0, 1'b0, 1'b0, 16'h0);
    rd(0, 8, -1, NOP);
    for (int k = 0; k < 8; k++) begin
      ref_m[k] = rnd();
      c(k == 0 ? WR : NOP, AP, 1'b0, 1'b1, ref_m[k]);
    end
    apb(1'b0, sbt_pkg::STAT_OFS, 32'h0, 32'h0000_0001, 1'b0);
    repeat (8) c(NOP, 0, 1'b0, 1'b0, 16'h0);
    apb(1'b0, sbt_pkg::STAT_OFS, 32'h0, 32'h0, 1'b0);
    c(ACT, 0, 1'b0, 1'b0, 16'h0);
    apb(1'b1, sbt_pkg::CFG_OFS, 32'h0000_0132, 32'h0, 1'b0);
    apb(1'b0, sbt_pkg::CFG_OFS, 32'h0, 32'h0000_0132, 1'b0);
    ref_m[4] = rnd();
    c(WR, 4, 1'b0, 1'b1, ref_m[4]);
    repeat (2) c(NOP, 0, 1'b0, 1'b1, rnd());
    apb(1'b0, sbt_pkg::STAT_OFS, 32'h0, 32'h0000_0001, 1'b0);
    cfg(2, 3);
    rd(0, 8, -1, NOP);
    $display("test precharge and modes done");
    for (int r = 2; r < 4; r++) begin
      cfg(r, 3);
      rd(1, 3, 1, BST);
      rd(2, 4, -1, sbt_pkg::CMD_PRE);
      c(ACT, 0, 1'b0, 1'b0, 16'h0);
    end
    $display("test read truncation done");
    cfg(2, 7);
    wb(510, 4, -1);
    c(BST, 0, 1'b0, 1'b1, rnd());
    rd(511, 3, -1, BST);
    $display("test page wrap done");
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule : sbt_burst_truncation_test
